// ===== logic/evt_pkg.sv
// How it works
// - Each event flag reads 0 until its event happens, then reads 1 until software writes 0; a software write of 1 also sets it.
// - Receive-begun flag sets when the receiver actually starts operating.
// - Transmit-begun flag sets when the transmitter actually starts operating.
// - Restart shortcut on: every receive-buffer-full event fires the begin-receive task.
// - Halt shortcut on: every receive-buffer-full event fires the halt-receive task.
// - Shortcut configuration resets to zero, so every shortcut starts disabled.
`default_nettype none
package evt_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_EVT = 5;
  // Event order used by flag cells and the interrupt status register.
  localparam int EV_ERROR = 0;
  localparam int EV_RX_TIMEOUT = 1;
  localparam int EV_RX_BEGUN = 2;
  localparam int EV_TX_BEGUN = 3;
  localparam int EV_TX_HALTED = 4;
  localparam logic [ADDR_W-1:0] OFF_ERROR = 12'h124;
  localparam logic [ADDR_W-1:0] OFF_RX_TIMEOUT = 12'h144;
  localparam logic [ADDR_W-1:0] OFF_RX_BEGUN = 12'h14c;
  localparam logic [ADDR_W-1:0] OFF_TX_BEGUN = 12'h150;
  localparam logic [ADDR_W-1:0] OFF_TX_HALTED = 12'h158;
  localparam logic [ADDR_W-1:0] OFF_SHORTCUT = 12'h200;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h400;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h404;
  localparam logic [ADDR_W-1:0] EVT_OFFS [NUM_EVT] = '{
    OFF_ERROR, OFF_RX_TIMEOUT, OFF_RX_BEGUN, OFF_TX_BEGUN, OFF_TX_HALTED};
  localparam int SC_RESTART_BIT = 5;
  localparam int SC_HALT_BIT = 6;
  localparam logic [DATA_W-1:0] SHORTCUT_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SHORTCUT_MASK = 32'h0000_0060;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [NUM_EVT-1:0] IRQ_RESET = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== logic/reg_wr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface reg_wr_if;
  logic                          wr_en;
  logic [evt_pkg::ADDR_W-1:0]    addr;
  logic [evt_pkg::DATA_W-1:0]    data;
  logic                          be0;
  modport src (output wr_en, output addr, output data, output be0);
  modport snk (input wr_en, input addr, input data, input be0);
endinterface
`default_nettype wire

// ===== logic/event_flag_cell.sv
`timescale 1ns/1ps
`default_nettype none
module event_flag_cell #(
  parameter logic [evt_pkg::ADDR_W-1:0] OFFSET = evt_pkg::OFF_ERROR
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic event_pulse,
  reg_wr_if.snk     wr,
  output var  logic flag_r
);
  logic hit;
  assign hit = wr.wr_en && wr.be0 && (wr.addr == OFFSET);
  // An event in the same cycle as a software write wins, so it is never lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= evt_pkg::FLAG_RESET;
    end else if (event_pulse) begin
      flag_r <= 1'b1;
    end else if (hit) begin
      flag_r <= wr.data[0];
    end
  end
endmodule // event_flag_cell
`default_nettype wire

// ===== logic/shortcut_unit.sv
`timescale 1ns/1ps
`default_nettype none
module shortcut_unit (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       rx_buffer_full_event,
  reg_wr_if.snk                           wr,
  output var  logic [evt_pkg::DATA_W-1:0] shortcut_config_r,
  output var  logic                       begin_receive_task_r,
  output var  logic                       halt_receive_task_r
);
  logic hit;
  assign hit = wr.wr_en && wr.be0 && (wr.addr == evt_pkg::OFF_SHORTCUT);
  // Only the two shortcut bits are stored; all other bits read as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shortcut_config_r <= evt_pkg::SHORTCUT_RESET;
    end else if (hit) begin
      shortcut_config_r <= wr.data & evt_pkg::SHORTCUT_MASK;
    end
  end
  // Both tasks may fire together; the receiver decides which one prevails.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      begin_receive_task_r <= 1'b0;
      halt_receive_task_r  <= 1'b0;
    end else begin
      begin_receive_task_r <= rx_buffer_full_event &&
                              shortcut_config_r[evt_pkg::SC_RESTART_BIT];
      halt_receive_task_r  <= rx_buffer_full_event &&
                              shortcut_config_r[evt_pkg::SC_HALT_BIT];
    end
  end
endmodule // shortcut_unit
`default_nettype wire

// ===== logic/uart_event_shortcut_regs.sv
`timescale 1ns/1ps
`default_nettype none
module uart_event_shortcut_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output var  logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  input  wire logic        error_event,
  input  wire logic        rx_timeout_event,
  input  wire logic        rx_begun_event,
  input  wire logic        tx_begun_event,
  input  wire logic        tx_halted_event,
  input  wire logic        rx_buffer_full_event,
  output var  logic        begin_receive_task,
  output var  logic        halt_receive_task,
  output var  logic        irq
);
  localparam int NE = evt_pkg::NUM_EVT;

  logic [11:0]  aw_addr_r;
  logic         aw_held_r;
  logic [31:0]  w_data_r;
  logic         w_be0_r;
  logic         w_held_r;
  logic         do_wr;
  logic         wr_mapped;
  logic [NE-1:0] events;
  logic [NE-1:0] flags;
  logic [NE-1:0] irq_status_r;
  logic [NE-1:0] irq_mask_r;
  logic [NE-1:0] irq_clr;
  logic [31:0]  shortcut_config_r;
  logic [31:0]  rd_data;
  logic         rd_mapped;

  reg_wr_if wr_bus ();

  assign events[evt_pkg::EV_ERROR]      = error_event;
  assign events[evt_pkg::EV_RX_TIMEOUT] = rx_timeout_event;
  assign events[evt_pkg::EV_RX_BEGUN]   = rx_begun_event;
  assign events[evt_pkg::EV_TX_BEGUN]   = tx_begun_event;
  assign events[evt_pkg::EV_TX_HALTED]  = tx_halted_event;

  // Write address and data are parked separately and committed once both are held.
  assign do_wr = aw_held_r && w_held_r && !s_axi_bvalid;

  assign wr_bus.wr_en = do_wr;
  assign wr_bus.addr  = aw_addr_r;
  assign wr_bus.data  = w_data_r;
  assign wr_bus.be0   = w_be0_r;

  always_comb begin
    wr_mapped = (aw_addr_r == evt_pkg::OFF_SHORTCUT) ||
                (aw_addr_r == evt_pkg::OFF_IRQ_STATUS) ||
                (aw_addr_r == evt_pkg::OFF_IRQ_MASK);
    for (int i = 0; i < NE; i++) begin
      if (aw_addr_r == evt_pkg::EVT_OFFS[i]) begin
        wr_mapped = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 12'h000;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held_r     <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r     <= 1'b1;
      aw_addr_r     <= {s_axi_awaddr[11:2], 2'b00};
      s_axi_awready <= 1'b0;
    end else if (!aw_held_r) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_be0_r      <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held_r     <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r     <= 1'b1;
      w_data_r     <= s_axi_wdata;
      w_be0_r      <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (!w_held_r) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= evt_pkg::RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? evt_pkg::RESP_OKAY : evt_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NE; g++) begin : g_flag
      event_flag_cell #(
        .OFFSET (evt_pkg::EVT_OFFS[g])
      ) u_flag (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .event_pulse (events[g]),
        .wr          (wr_bus.snk),
        .flag_r      (flags[g])
      );
    end
  endgenerate

  shortcut_unit u_shortcut (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .rx_buffer_full_event (rx_buffer_full_event),
    .wr                   (wr_bus.snk),
    .shortcut_config_r    (shortcut_config_r),
    .begin_receive_task_r (begin_receive_task),
    .halt_receive_task_r  (halt_receive_task)
  );

  // Interrupt status is write-one-to-clear; a new event beats a clear in the same cycle.
  assign irq_clr = (do_wr && w_be0_r && aw_addr_r == evt_pkg::OFF_IRQ_STATUS) ?
                   w_data_r[NE-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= evt_pkg::IRQ_RESET;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= evt_pkg::IRQ_RESET;
    end else if (do_wr && w_be0_r && aw_addr_r == evt_pkg::OFF_IRQ_MASK) begin
      irq_mask_r <= w_data_r[NE-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

  always_comb begin
    rd_data   = 32'h0000_0000;
    rd_mapped = 1'b1;
    if (s_axi_araddr[11:2] == evt_pkg::OFF_SHORTCUT[11:2]) begin
      rd_data = shortcut_config_r;
    end else if (s_axi_araddr[11:2] == evt_pkg::OFF_IRQ_STATUS[11:2]) begin
      rd_data[NE-1:0] = irq_status_r;
    end else if (s_axi_araddr[11:2] == evt_pkg::OFF_IRQ_MASK[11:2]) begin
      rd_data[NE-1:0] = irq_mask_r;
    end else begin
      rd_mapped = 1'b0;
      for (int i = 0; i < NE; i++) begin
        if (s_axi_araddr[11:2] == evt_pkg::EVT_OFFS[i][11:2]) begin
          rd_data[0] = flags[i];
          rd_mapped  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= evt_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_mapped ? evt_pkg::RESP_OKAY : evt_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Checks.
  default clocking cb @(posedge aclk);
  endclocking

  logic clr_error;
  logic clr_rx_timeout;
  assign clr_error      = do_wr && w_be0_r && !w_data_r[0] &&
                          aw_addr_r == evt_pkg::OFF_ERROR;
  assign clr_rx_timeout = do_wr && w_be0_r && !w_data_r[0] &&
                          aw_addr_r == evt_pkg::OFF_RX_TIMEOUT;

  sequence s_full_restart;
    rx_buffer_full_event && shortcut_config_r[evt_pkg::SC_RESTART_BIT];
  endsequence
  sequence s_full_halt;
    rx_buffer_full_event && shortcut_config_r[evt_pkg::SC_HALT_BIT];
  endsequence
  sequence s_wr_commit;
    do_wr;
  endsequence
  sequence s_resp_then_free;
    s_axi_bvalid ##1 (!s_axi_bvalid || !$past(s_axi_bready));
  endsequence

  chk_rx_begun_flag: assert property (disable iff (!aresetn)
    rx_begun_event |=> flags[evt_pkg::EV_RX_BEGUN])
    else $error("receive-begun flag not set after its event");

  chk_tx_begun_flag: assert property (disable iff (!aresetn)
    tx_begun_event |=> flags[evt_pkg::EV_TX_BEGUN])
    else $error("transmit-begun flag not set after its event");

  chk_restart_on_full: assert property (disable iff (!aresetn)
    s_full_restart |=> begin_receive_task ##1 (!begin_receive_task ||
                                               $past(rx_buffer_full_event)))
    else $error("begin-receive task not fired as one pulse");

  chk_no_restart_off: assert property (disable iff (!aresetn)
    !(rx_buffer_full_event && shortcut_config_r[evt_pkg::SC_RESTART_BIT])
    |=> !begin_receive_task)
    else $error("begin-receive task fired without shortcut");

  chk_halt_on_full: assert property (disable iff (!aresetn)
    s_full_halt |=> halt_receive_task)
    else $error("halt-receive task not fired");

  chk_no_halt_off: assert property (disable iff (!aresetn)
    !(rx_buffer_full_event && shortcut_config_r[evt_pkg::SC_HALT_BIT])
    |=> !halt_receive_task)
    else $error("halt-receive task fired without shortcut");

  chk_shortcut_reset: assert property (
    !aresetn |=> shortcut_config_r == evt_pkg::SHORTCUT_RESET)
    else $error("shortcuts not disabled by reset");

  chk_flag_held: assert property (disable iff (!aresetn)
    flags[evt_pkg::EV_ERROR] && !clr_error |=> flags[evt_pkg::EV_ERROR])
    else $error("error flag dropped without a clearing write");

  chk_flag_cleared: assert property (disable iff (!aresetn)
    clr_error && !error_event |=> !flags[evt_pkg::EV_ERROR])
    else $error("error flag not cleared by writing zero");

  chk_flag_stays_low: assert property (disable iff (!aresetn)
    !flags[evt_pkg::EV_RX_TIMEOUT] && !rx_timeout_event && !(do_wr && w_be0_r &&
    w_data_r[0] && aw_addr_r == evt_pkg::OFF_RX_TIMEOUT)
    |=> !flags[evt_pkg::EV_RX_TIMEOUT])
    else $error("timeout flag set without an event");

  chk_set_beats_clear: assert property (disable iff (!aresetn)
    clr_rx_timeout && rx_timeout_event |=> flags[evt_pkg::EV_RX_TIMEOUT])
    else $error("event lost against a clearing write");

  chk_write_resp: assert property (disable iff (!aresetn)
    s_wr_commit |=> s_resp_then_free)
    else $error("write response not raised after commit");

  chk_irq_level: assert property (disable iff (!aresetn)
    |(irq_status_r & irq_mask_r) |=> irq)
    else $error("interrupt not raised for unmasked status");

endmodule // uart_event_shortcut_regs
`default_nettype wire

// ===== verification/uart_event_shortcut_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_event_shortcut_regs_tb;
  logic        aclk;
  logic        aresetn;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic        full_ev;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic        begin_task;
  logic        halt_task;
  logic        irq;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0]  wstrb;
  logic [4:0]  ev;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          err_total;
  int          comparisons;
  int          nbeg;
  int          nhalt;

  uart_event_shortcut_regs uart_event_shortcut_regs_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .error_event(ev[0]), .rx_timeout_event(ev[1]),
    .rx_begun_event(ev[2]), .tx_begun_event(ev[3]), .tx_halted_event(ev[4]),
    .rx_buffer_full_event(full_ev), .begin_receive_task(begin_task),
    .halt_receive_task(halt_task), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The bus tasks only queue what they expect; the monitor below judges the answers.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
    int n;
    bq.push_back(resp);
    // One idle edge keeps the released handshake signals from being driven twice at once.
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (!(bvalid && bready) && n < 50);
    bready <= 1'b0;
    if (n >= 50) err_total++;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
    int n;
    rq.push_back({resp, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (!(rvalid && rready) && n < 50);
    rready <= 1'b0;
    if (n >= 50) err_total++;
  endtask

  // Holds the event lines for n cycles, so n above one gives back-to-back events.
  task automatic pulse(input logic [4:0] m, input logic f, input int n);
    ev <= m;
    full_ev <= f;
    repeat (n) @(posedge aclk);
    ev <= 5'h00;
    full_ev <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) check({32'h0000_0000, bresp}, {32'h0000_0000, bq.pop_front()});
    if (begin_task) nbeg++;
    if (halt_task) nhalt++;
  end

  initial begin
    #200_000;
    err_total++;
    print_verdict;
  end

  initial begin
    int          b0;
    int          h0;
    int          k;
    logic [4:0]  m;
    logic [31:0] d;
    void'($urandom(32'h0000_c3eb));
    {awvalid, wvalid, bready, arvalid, rready, full_ev} = 6'h00;
    {awaddr, araddr, wdata, wstrb, ev} = '0;
    err_total = 0;
    comparisons = 0;
    nbeg = 0;
    nhalt = 0;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 5; i++) rd(evt_pkg::EVT_OFFS[i], 32'h0000_0000, evt_pkg::RESP_OKAY);
    rd(evt_pkg::OFF_SHORTCUT, 32'h0000_0000, evt_pkg::RESP_OKAY);
    rd(evt_pkg::OFF_IRQ_STATUS, 32'h0000_0000, evt_pkg::RESP_OKAY);
    rd(evt_pkg::OFF_IRQ_MASK, 32'h0000_0000, evt_pkg::RESP_OKAY);
    rd(12'h300, 32'h0000_0000, evt_pkg::RESP_SLVERR);
    wr(12'h300, 32'hffff_ffff, evt_pkg::RESP_SLVERR);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) begin
      pulse(5'(1 << i), 1'b0, 1);
      for (int j = 0; j < 5; j++) rd(evt_pkg::EVT_OFFS[j], 32'(i == j), evt_pkg::RESP_OKAY);
      wr(evt_pkg::EVT_OFFS[i], 32'h0000_0000, evt_pkg::RESP_OKAY);
      rd(evt_pkg::EVT_OFFS[i], 32'h0000_0000, evt_pkg::RESP_OKAY);
    end
    $display("test single events done");
    repeat (4) begin
      m = 5'($urandom);
      pulse(m, 1'b0, 1);
      for (int j = 0; j < 5; j++) rd(evt_pkg::EVT_OFFS[j], 32'(m[j]), evt_pkg::RESP_OKAY);
      for (int j = 0; j < 5; j++) wr(evt_pkg::EVT_OFFS[j], 32'h0000_0000, evt_pkg::RESP_OKAY);
    end
    wr(evt_pkg::OFF_IRQ_STATUS, 32'h0000_001f, evt_pkg::RESP_OKAY);
    $display("test random events done");
    // Stray upper bits must not stick; only the two shortcut bits are stored.
    for (int c = 0; c < 4; c++) begin
      d = ($urandom & 32'hffff_ff9f) | 32'(c << 5);
      wr(evt_pkg::OFF_SHORTCUT, d, evt_pkg::RESP_OKAY);
      rd(evt_pkg::OFF_SHORTCUT, 32'(c << 5), evt_pkg::RESP_OKAY);
      b0 = nbeg;
      h0 = nhalt;
      pulse(5'h00, 1'b1, 2);
      repeat (2) @(posedge aclk);
      check(34'(nbeg - b0), (c & 1) ? 34'h2 : 34'h0);
      check(34'(nhalt - h0), (c & 2) ? 34'h2 : 34'h0);
    end
    $display("test shortcuts done");
    k = $urandom_range(4, 0);
    wr(evt_pkg::OFF_IRQ_MASK, 32'(1 << k), evt_pkg::RESP_OKAY);
    pulse(5'(1 << ((k + 1) % 5)), 1'b0, 1);
    repeat (4) @(posedge aclk);
    check({33'h0, irq}, 34'h0);
    pulse(5'(1 << k), 1'b0, 1);
    repeat (4) @(posedge aclk);
    check({33'h0, irq}, 34'h1);
    d = 32'(1 << k) | 32'(1 << ((k + 1) % 5));
    rd(evt_pkg::OFF_IRQ_STATUS, d, evt_pkg::RESP_OKAY);
    wr(evt_pkg::OFF_IRQ_STATUS, 32'(1 << k), evt_pkg::RESP_OKAY);
    repeat (4) @(posedge aclk);
    check({33'h0, irq}, 34'h0);
    rd(evt_pkg::OFF_IRQ_STATUS, 32'(1 << ((k + 1) % 5)), evt_pkg::RESP_OKAY);
    $display("test interrupt done");
    wr(evt_pkg::OFF_SHORTCUT, 32'h0000_0060, evt_pkg::RESP_OKAY);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(evt_pkg::OFF_SHORTCUT, 32'h0000_0000, evt_pkg::RESP_OKAY);
    b0 = nbeg + nhalt;
    pulse(5'h00, 1'b1, 1);
    repeat (2) @(posedge aclk);
    check(34'(nbeg + nhalt - b0), 34'h0);
    $display("test second reset done");
    repeat (4) @(posedge aclk);
    print_verdict;
  end
endmodule // uart_event_shortcut_regs_tb
`default_nettype wire
